// File: verilog/twr_pkg.sv
// Package: constants and carriers for the timer wide register access block
package twr_pkg;
    // ==========================================================
    // Byte locations on the CPU side (index of an 8-bit I/O slot)
    localparam logic [3:0] ADDR_CNT_L = 4'h0;
    localparam logic [3:0] ADDR_CNT_H = 4'h1;
    localparam logic [3:0] ADDR_CMPA_L = 4'h2;
    localparam logic [3:0] ADDR_CMPA_H = 4'h3;
    localparam logic [3:0] ADDR_CMPB_L = 4'h4;
    localparam logic [3:0] ADDR_CMPB_H = 4'h5;
    localparam logic [3:0] ADDR_CMPC_L = 4'h6;
    localparam logic [3:0] ADDR_CMPC_H = 4'h7;
    localparam logic [3:0] ADDR_CAP_L = 4'h8;
    localparam logic [3:0] ADDR_CAP_H = 4'h9;
    localparam logic [3:0] ADDR_CTRL_B = 4'hA;
    localparam logic [3:0] ADDR_CTRL_C = 4'hB;
    // ==========================================================
    // Field positions inside the control bytes
    localparam int CSEL_LSB = 0;
    localparam int WGM3_BIT = 4;
    localparam int FOC_C_BIT = 5;
    localparam int FOC_B_BIT = 6;
    localparam int FOC_A_BIT = 7;
    // ==========================================================
    // Reset values
    localparam logic [7:0] TEMP_RESET = 8'h00;
    localparam logic [15:0] WIDE_RESET = 16'h0000;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [2:0] CSEL_STOP = 3'h0;

    // CPU byte access carrier
    typedef struct packed {
        logic rd;
        logic wr;
        logic [3:0] addr;
        logic [7:0] wdata;
    } twr_bus_t;

    // Values handed to the counter unit
    typedef struct packed {
        logic [15:0] cmp_a;
        logic [15:0] cmp_b;
        logic [15:0] cmp_c;
        logic [2:0] clock_source_select;
        logic waveform_mode_bit3;
        logic force_compare_a;
        logic force_compare_b;
        logic force_compare_c;
        logic cmp_c_irq_mask;
    } twr_cfg_t;
endpackage : twr_pkg

// File: verilog/twr_temp.sv
// Shared high byte temporary register
`timescale 1ns/10ps
module twr_temp (
    input wire logic clock,
    input wire logic rstn,
    input wire logic load,
    input wire logic [7:0] din,
    output logic [7:0] q
);
    import twr_pkg::*;

    typedef struct packed {
        logic [7:0] value;
    } twr_temp_state_t;

    twr_temp_state_t state;
    twr_temp_state_t next_state;

    // ==========================================================
    // Holds its value unless loaded; low byte writes never touch it
    always_comb begin
        next_state = state;
        if (load) begin
            next_state.value = din;
        end
    end

    // Register the state
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state <= '{value: TEMP_RESET};
        end else begin
            state <= next_state;
        end
    end

    assign q = state.value;
endmodule : twr_temp

// File: verilog/twr_flag.sv
// Sticky flag where hardware set wins over software clear
`timescale 1ns/10ps
module twr_flag (
    input wire logic clock,
    input wire logic rstn,
    input wire logic set,
    input wire logic clear,
    output logic q
);
    typedef struct packed {
        logic flag;
    } twr_flag_state_t;

    twr_flag_state_t state;
    twr_flag_state_t next_state;

    // ==========================================================
    // Set is checked last so a same-cycle event is never lost
    always_comb begin
        next_state = state;
        if (clear) begin
            next_state.flag = 1'b0;
        end
        if (set) begin
            next_state.flag = 1'b1;
        end
    end

    // Register the state
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state <= '{flag: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign q = state.flag;
endmodule : twr_flag

// File: verilog/twr_access.sv
// Wide register access path of a 16-bit timer: counter, compares, capture, controls
//
// Notes on behaviour
// - Counter, three compares and capture are 16-bit, reached by two byte accesses.
// - One 8-bit temporary byte is shared by all wide registers of the timer.
// - Low byte write loads temporary high and written low together in one cycle.
// - Counter or capture low byte read copies the high byte into the temporary register same cycle.
// - Compare reads bypass the temporary byte and return their own high byte.
// - The temporary byte survives low byte writes, so one high write serves many.
// - A three-bit clock source select sits in control register B.
// - Control register C holds force compare bits for channels A, B and C.
// - Waveform mode bit 3 sits in control register B.
// - Compare channel C has its own interrupt flag and mask bit.
// - Clock select zero stops the counter; CPU access still works.
// - A CPU counter write beats a clear or count in the same cycle.
`timescale 1ns/10ps
module twr_access #(
    parameter int WIDTH = 16
) (
    input wire logic clock,
    input wire logic rstn,
    input twr_pkg::twr_bus_t bus,
    input wire logic clk_tick,
    input wire logic count_up,
    input wire logic count_clear,
    input wire logic capture_event,
    input wire logic cmp_c_match,
    input wire logic cmp_c_flag_clear,
    output logic [7:0] rdata,
    output logic [WIDTH-1:0] counter_value,
    output logic [WIDTH-1:0] capture_value,
    output twr_pkg::twr_cfg_t cfg,
    output logic cmp_c_flag,
    output logic cmp_c_irq
);
    import twr_pkg::*;

    // Module state other than the shared byte and the channel C flag lives in one packed struct
    typedef struct packed {
        logic [7:0] rdata;
        logic [WIDTH-1:0] cnt;
        logic [WIDTH-1:0] cmp_a;
        logic [WIDTH-1:0] cmp_b;
        logic [WIDTH-1:0] cmp_c;
        logic [WIDTH-1:0] cap;
        logic [7:0] ctrl_b;
        logic [7:0] ctrl_c;
        logic irq;
    } twr_state_t;

    twr_state_t state;
    twr_state_t next_state;

    logic [7:0] temp_q;
    logic temp_load;
    logic [7:0] temp_din;
    logic flag_q;

    // ==========================================================
    // Helpers
    function automatic logic [WIDTH-1:0] join_bytes(input logic [7:0] hi, input logic [7:0] lo);
        join_bytes = {hi, lo};
    endfunction : join_bytes

    function automatic logic is_high_slot(input logic [3:0] a);
        is_high_slot = (a == ADDR_CNT_H) || (a == ADDR_CMPA_H) || (a == ADDR_CMPB_H) ||
                       (a == ADDR_CMPC_H) || (a == ADDR_CAP_H);
    endfunction : is_high_slot

    // ==========================================================
    // Shared temporary byte
    twr_temp u_temp (
        .clock(clock),
        .rstn(rstn),
        .load(temp_load),
        .din(temp_din),
        .q(temp_q)
    );

    // Compare channel C flag; the match set wins over a clear
    twr_flag u_flag_c (
        .clock(clock),
        .rstn(rstn),
        .set(cmp_c_match),
        .clear(cmp_c_flag_clear),
        .q(flag_q)
    );

    // ==========================================================
    // Temporary byte loading: high writes and counter/capture low reads
    always_comb begin
        temp_load = 1'b0;
        temp_din = bus.wdata;
        if (bus.wr && is_high_slot(bus.addr)) begin
            temp_load = 1'b1;
        end else if (bus.rd && bus.addr == ADDR_CNT_L) begin
            temp_load = 1'b1;
            temp_din = state.cnt[15:8];
        end else if (bus.rd && bus.addr == ADDR_CAP_L) begin
            temp_load = 1'b1;
            temp_din = state.cap[15:8];
        end
    end

    // ==========================================================
    // Next state: CPU writes, counting, capture and read data
    always_comb begin
        next_state = state;
        next_state.irq = flag_q & state.ctrl_c[0];
        // Counter advances only on a tick with a clock source chosen
        if (count_clear) begin
            next_state.cnt = '0;
        end else if (clk_tick && state.ctrl_b[2:0] != CSEL_STOP) begin
            next_state.cnt = count_up ? state.cnt + 16'h0001 : state.cnt - 16'h0001;
        end
        if (capture_event) begin
            next_state.cap = state.cnt;
        end
        // Low byte writes commit temp plus data; temp itself is kept
        if (bus.wr) begin
            case (bus.addr)
                ADDR_CNT_L: next_state.cnt = join_bytes(temp_q, bus.wdata);
                ADDR_CMPA_L: next_state.cmp_a = join_bytes(temp_q, bus.wdata);
                ADDR_CMPB_L: next_state.cmp_b = join_bytes(temp_q, bus.wdata);
                ADDR_CMPC_L: next_state.cmp_c = join_bytes(temp_q, bus.wdata);
                ADDR_CAP_L: next_state.cap = join_bytes(temp_q, bus.wdata);
                ADDR_CTRL_B: next_state.ctrl_b = bus.wdata;
                ADDR_CTRL_C: next_state.ctrl_c = bus.wdata;
                default: next_state.ctrl_b = state.ctrl_b;
            endcase
        end
        // Read data is registered, one cycle after the strobe
        if (bus.rd) begin
            case (bus.addr)
                ADDR_CNT_L: next_state.rdata = state.cnt[7:0];
                ADDR_CMPA_L: next_state.rdata = state.cmp_a[7:0];
                ADDR_CMPB_L: next_state.rdata = state.cmp_b[7:0];
                ADDR_CMPC_L: next_state.rdata = state.cmp_c[7:0];
                ADDR_CAP_L: next_state.rdata = state.cap[7:0];
                ADDR_CMPA_H: next_state.rdata = state.cmp_a[15:8];
                ADDR_CMPB_H: next_state.rdata = state.cmp_b[15:8];
                ADDR_CMPC_H: next_state.rdata = state.cmp_c[15:8];
                ADDR_CNT_H: next_state.rdata = temp_q;
                ADDR_CAP_H: next_state.rdata = temp_q;
                ADDR_CTRL_B: next_state.rdata = state.ctrl_b;
                // Force bits are strobes and read back as zero
                ADDR_CTRL_C: next_state.rdata = {3'h0, state.ctrl_c[4:0]};
                default: next_state.rdata = 8'h00;
            endcase
        end
        // Force compare bits act for one cycle only
        if (!(bus.wr && bus.addr == ADDR_CTRL_C)) begin
            next_state.ctrl_c[FOC_A_BIT] = 1'b0;
            next_state.ctrl_c[FOC_B_BIT] = 1'b0;
            next_state.ctrl_c[FOC_C_BIT] = 1'b0;
        end
    end

    // ==========================================================
    // Register the state
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state <= '{rdata: 8'h00, cnt: WIDE_RESET, cmp_a: WIDE_RESET, cmp_b: WIDE_RESET,
                       cmp_c: WIDE_RESET, cap: WIDE_RESET, ctrl_b: CTRL_RESET, ctrl_c: CTRL_RESET,
                       irq: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Outputs, all from flip-flops
    assign rdata = state.rdata;
    assign counter_value = state.cnt;
    assign capture_value = state.cap;
    assign cmp_c_flag = flag_q;
    assign cmp_c_irq = state.irq;
    // One assignment fills the whole carrier so the port has a single driver
    assign cfg = '{
        cmp_a: state.cmp_a,
        cmp_b: state.cmp_b,
        cmp_c: state.cmp_c,
        clock_source_select: state.ctrl_b[CSEL_LSB +: 3],
        waveform_mode_bit3: state.ctrl_b[WGM3_BIT],
        force_compare_a: state.ctrl_c[FOC_A_BIT],
        force_compare_b: state.ctrl_c[FOC_B_BIT],
        force_compare_c: state.ctrl_c[FOC_C_BIT],
        cmp_c_irq_mask: state.ctrl_c[0]
    };
endmodule : twr_access

// File: tb/twr_access_properties.sv
// Checker for the timer wide register access block
`timescale 1ns/10ps
module twr_access_props #(
    parameter int WIDTH = 16
) (
    input wire logic clock,
    input wire logic rstn,
    input twr_pkg::twr_bus_t bus,
    input wire logic count_clear,
    input wire logic cmp_c_match,
    input wire logic [7:0] rdata,
    input wire logic [WIDTH-1:0] counter_value,
    input twr_pkg::twr_cfg_t cfg,
    input wire logic cmp_c_flag,
    input wire logic cmp_c_irq
);
    import twr_pkg::*;
    // ==========================================================
    // Clocking
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    cnt_low_write_a: assert property (bus.wr && bus.addr == ADDR_CNT_L |=> counter_value[7:0] == $past(bus.wdata))
        else $error("counter low write lost");
    cmp_high_hold_a: assert property (bus.wr && bus.addr == ADDR_CMPB_H |=> $stable(cfg.cmp_b))
        else $error("high byte write changed compare");
    cmp_high_read_a: assert property (bus.rd && bus.addr == ADDR_CMPA_H |=> rdata == $past(cfg.cmp_a[15:8]))
        else $error("compare high read wrong");
    cnt_low_read_a: assert property (bus.rd && bus.addr == ADDR_CNT_L |=> rdata == $past(counter_value[7:0]))
        else $error("counter low read wrong");
    stop_hold_a: assert property (cfg.clock_source_select == CSEL_STOP && !count_clear
        && !(bus.wr && bus.addr == ADDR_CNT_L) |=> $stable(counter_value)) else $error("stopped counter moved");
    force_pulse_a: assert property (bus.wr && bus.addr == ADDR_CTRL_C && bus.wdata[FOC_A_BIT]
        |=> cfg.force_compare_a ##1 !cfg.force_compare_a) else $error("force bit not one pulse");
    ctrl_b_fields_a: assert property (bus.wr && bus.addr == ADDR_CTRL_B |=> cfg.clock_source_select ==
        $past(bus.wdata[2:0]) && cfg.waveform_mode_bit3 == $past(bus.wdata[WGM3_BIT])) else $error("ctrl B fields");
    flag_set_a: assert property (cmp_c_match |=> cmp_c_flag)
        else $error("compare C flag not set");
    irq_out_a: assert property (cmp_c_flag && cfg.cmp_c_irq_mask |=> cmp_c_irq)
        else $error("compare C request missing");
endmodule : twr_access_props
bind twr_access twr_access_props #(.WIDTH(WIDTH)) i_props (.clock(clock), .rstn(rstn), .bus(bus),
    .count_clear(count_clear), .cmp_c_match(cmp_c_match), .rdata(rdata), .counter_value(counter_value),
    .cfg(cfg), .cmp_c_flag(cmp_c_flag), .cmp_c_irq(cmp_c_irq));

// File: tb/twr_cpu_model.sv
// CPU side byte access model
`timescale 1ns/10ps
module twr_cpu_model (
    input wire logic clock,
    input wire logic [7:0] rdata,
    output twr_pkg::twr_bus_t bus
);
    import twr_pkg::*;
    initial bus = '0;
    // One strobe per rising edge; released lines flip so no stale value lingers
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge clock);
        bus <= '{rd: !w, wr: w, addr: a, wdata: d};
        @(negedge clock);
        q = rdata;
        bus <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask : acc
    // Whole access in one process, so nothing can slip between the two bytes
    task automatic wr16(input logic [3:0] a, input logic [15:0] v);
        logic [7:0] q;
        acc(1'b1, a | 4'h1, v[15:8], q);
        acc(1'b1, a, v[7:0], q);
    endtask : wr16
    task automatic rd16(input logic [3:0] a, output logic [15:0] v);
        acc(1'b0, a, 8'h00, v[7:0]);
        acc(1'b0, a | 4'h1, 8'h00, v[15:8]);
    endtask : rd16
endmodule : twr_cpu_model

// File: tb/tb_top.sv
// Self-checking bench for the timer wide register access block
`timescale 1ns/10ps
module tb_top;
    import twr_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic count_up = 1'b0, count_clear = 1'b0, capture_event = 1'b0;
    logic clk_tick, held_tick = 1'b0, rnd_bit = 1'b0;
    logic cmp_c_match = 1'b0, cmp_c_flag_clear = 1'b0, rand_tick = 1'b0;
    twr_bus_t bus;
    twr_cfg_t cfg;
    logic [7:0] rdata, b, d;
    logic [15:0] counter_value, capture_value, v;
    logic [15:0] m [5];
    logic cmp_c_flag, cmp_c_irq;
    logic [31:0] seed = 32'd66435;
    int n_fail = 0;
    int checks_done = 0;
    always #25 clock = ~clock;
    twr_access #(.WIDTH(16)) i_dut (.clock(clock), .rstn(rstn), .bus(bus), .clk_tick(clk_tick),
        .count_up(count_up), .count_clear(count_clear), .capture_event(capture_event),
        .cmp_c_match(cmp_c_match), .cmp_c_flag_clear(cmp_c_flag_clear), .rdata(rdata),
        .counter_value(counter_value), .capture_value(capture_value), .cfg(cfg),
        .cmp_c_flag(cmp_c_flag), .cmp_c_irq(cmp_c_irq));
    twr_cpu_model i_cpu (.clock(clock), .rdata(rdata), .bus(bus));
    function automatic logic [15:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[15:0];
    endfunction : rnd
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test
    // Random ticks while stopped must never move the counter; one driver, so a held tick is not overwritten
    always @(negedge clock) rnd_bit <= (rnd() > 16'h7FFF);
    assign clk_tick = rand_tick ? rnd_bit : held_tick;
    initial begin
        #1000000;
        n_fail++;
        finish_test();
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(negedge clock);
        rstn = 1'b1;
        for (int i = 0; i < 5; i++) begin
            i_cpu.rd16(4'(2 * i), v);
            chk(v, WIDE_RESET);
        end
        rand_tick = 1'b1;
        for (int n = 0; n < 20; n++) begin
            for (int i = 0; i < 5; i++) begin
                m[i] = rnd();
                i_cpu.wr16(4'(2 * i), m[i]);
            end
            for (int i = 0; i < 5; i++) begin
                i_cpu.rd16(4'(2 * i), v);
                chk(v, m[i]);
            end
        end
        // Compare reads go around the shared byte
        b = 8'(rnd());
        i_cpu.acc(1'b1, ADDR_CNT_H, b, d);
        chk(counter_value, m[0]);
        i_cpu.acc(1'b0, ADDR_CMPA_L, 8'h00, d);
        i_cpu.acc(1'b0, ADDR_CMPA_H, 8'h00, d);
        chk(16'(d), 16'(m[1][15:8]));
        i_cpu.acc(1'b0, ADDR_CNT_H, 8'h00, d);
        chk(16'(d), 16'(b));
        // One high byte serves three commits
        i_cpu.acc(1'b1, ADDR_CMPB_H, b, d);
        for (int i = 1; i < 4; i++) begin
            m[i] = {b, 8'(rnd())};
            i_cpu.acc(1'b1, 4'(2 * i), m[i][7:0], d);
        end
        chk(cfg.cmp_a, m[1]);
        chk(cfg.cmp_b, m[2]);
        chk(cfg.cmp_c, m[3]);
        rand_tick = 1'b0;
        count_clear = 1'b1;
        i_cpu.wr16(ADDR_CNT_L, 16'h01FF);
        count_clear = 1'b0;
        chk(counter_value, 16'h01FF);
        for (int s = 0; s < 8; s++) begin
            b = (8'(rnd()) & 8'hF8) | 8'(s);
            i_cpu.acc(1'b1, ADDR_CTRL_B, b, d);
            chk(16'({cfg.waveform_mode_bit3, cfg.clock_source_select}), 16'({b[4], b[2:0]}));
        end
        // Count five up and two down, then capture the result
        i_cpu.acc(1'b1, ADDR_CTRL_B, 8'h01, d);
        count_up = 1'b1;
        held_tick = 1'b1;
        repeat (5) @(negedge clock);
        count_up = 1'b0;
        repeat (2) @(negedge clock);
        held_tick = 1'b0;
        chk(counter_value, 16'h0202);
        i_cpu.acc(1'b1, ADDR_CTRL_B, 8'h00, d);
        capture_event = 1'b1;
        @(negedge clock);
        capture_event = 1'b0;
        chk(capture_value, 16'h0202);
        i_cpu.rd16(ADDR_CAP_L, v);
        chk(v, 16'h0202);
        i_cpu.acc(1'b1, ADDR_CTRL_C, 8'hE1, d);
        chk(16'(cfg.cmp_c_irq_mask), 16'h0001);
        chk(16'({cfg.force_compare_a, cfg.force_compare_b, cfg.force_compare_c}), 16'h0007);
        cmp_c_match = 1'b1;
        @(negedge clock);
        cmp_c_match = 1'b0;
        chk(16'({cfg.force_compare_a, cfg.force_compare_b, cfg.force_compare_c}), 16'h0000);
        @(negedge clock);
        chk(16'({cmp_c_flag, cmp_c_irq}), 16'h0003);
        cmp_c_flag_clear = 1'b1;
        @(negedge clock);
        cmp_c_flag_clear = 1'b0;
        chk(16'(cmp_c_flag), 16'h0000);
        // Match and clear in one cycle: the match must win
        cmp_c_match = 1'b1;
        cmp_c_flag_clear = 1'b1;
        @(negedge clock);
        cmp_c_match = 1'b0;
        cmp_c_flag_clear = 1'b0;
        chk(16'(cmp_c_flag), 16'h0001);
        // Force bits read back as zero, the mask bit as stored
        i_cpu.acc(1'b0, ADDR_CTRL_C, 8'h00, d);
        chk(16'(d), 16'h0001);
        // Mid-run reset brings every register and the shared byte back to zero
        rstn = 1'b0;
        repeat (2) @(negedge clock);
        rstn = 1'b1;
        chk(counter_value | capture_value | cfg.cmp_a, 16'h0000);
        i_cpu.acc(1'b0, ADDR_CNT_H, 8'h00, d);
        chk(16'(d), 16'h0000);
        i_cpu.acc(1'b0, 4'hF, 8'h00, d);
        chk(16'(d), 16'h0000);
        finish_test();
    end
endmodule : tb_top
